// ### furnace_timing_pkg.sv
// constants for the furnace timing setup block
// assumes a 20 MHz controller clock; all delays are held in seconds, the clock period and SEC_NS in ns
package furnace_timing_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SEC_NS        = 1000000000;
    localparam int unsigned SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
    localparam logic [11:0] PREPURGE_S    = 12'h01e;
    localparam logic [11:0] INTERPURGE_S  = 12'h03c;
    localparam logic [11:0] POSTPURGE_S   = 12'h00f;
    localparam logic [11:0] COOL_ON_S     = 12'h005;
    localparam logic [11:0] COOL_OFF_LO_S = 12'h000;
    localparam logic [11:0] COOL_OFF_HI_S = 12'h03c;
    localparam logic [1:0]  MAX_RETRIES   = 2'h2;
    localparam logic [1:0]  MAX_RECYCLES  = 2'h3;
    localparam logic [11:0] RESTART_S     = 12'he10;
    localparam logic [11:0] FLAME_FAIL_S  = 12'h002;
    localparam logic [11:0] COMP_OFF_S    = 12'h12c;
    localparam logic [11:0] FALSE_FLAME_S = 12'h014;
    localparam logic [3:0]  LOCK_CYCLES   = 4'ha;
    localparam logic [11:0] HEAT_ON_LO_S  = 12'h01e;
    localparam logic [11:0] HEAT_ON_HI_S  = 12'h03c;
    localparam logic [11:0] HEAT_OFF_00_S = 12'h078;
    localparam logic [11:0] HEAT_OFF_01_S = 12'h0b4;
    localparam logic [11:0] HEAT_OFF_10_S = 12'h05a;
    localparam logic [11:0] HEAT_OFF_11_S = 12'h03c;
    localparam logic [11:0] WARM_FIRST_S  = 12'h011;
    localparam logic [11:0] WARM_NEXT_S   = 12'h01b;
    localparam logic [11:0] WARM_LONG_S   = 12'h01e;
    localparam logic [3:0]  ACT_00_S      = 4'h1;
    localparam logic [3:0]  ACT_MID_S     = 4'h3;
    localparam logic [3:0]  ACT_11_S      = 4'h5;
    localparam logic [3:0]  RECOG_S       = 4'h3;
    localparam logic [3:0]  FIELD_RESET   = 4'h0;
    localparam logic [1:0]  SAFETY_RESET  = 2'h0;
    typedef enum logic [1:0] {
        TRIAL_IDLE  = 2'b00,
        TRIAL_ACT   = 2'b01,
        TRIAL_RECOG = 2'b10
    } trial_state_t;
endpackage

// ### furnace_timing_config.sv
// timing setup for a single-stage hot-surface-ignition furnace sequencer
// switch and jumper pins are asynchronous; sequencer strobes share clk;
// the non-volatile store presents its contents while nvm_valid is high
`timescale 1ns/1ns
`default_nettype none
// Operation
// R1 - with the jumper fitted, the safety selection is stored after ten heat cycles unchanged.
// R2 - removing the jumper stores the present safety selection for good.
// R3 - once stored, later safety switch changes are ignored.
// R4 - a field switch change only affects delays that start after it.
// R5 - prepurge 30 s, inter-trial purge 60 s and postpurge 15 s are fixed.
// R6 - cool blower starts 5 s after demand and runs on 0 s or 60 s after it.
// R7 - two retries make three trials, then soft lockout for one hour.
// R8 - at most three flame-loss recycles per heat demand.
// R9 - flame loss is answered within 2 s.
// R10 - the compressor stays off at least 5 minutes between cycles.
// R11 - false flame is judged over a 20 s window.
// R12 - heat fan on delay runs from trial entry, 30 s or 60 s.
// R13 - heat fan off delay from the two-bit select: 120, 180, 90 or 60 s.
// R14 - igniter warm-up is 17 s first and 27 s later, or 30 s always.
// R15 - trial length 4, 6 or 8 s with 1, 3 or 5 s activation and 3 s recognition.
// R16 - every switch defaults to off.
// R17 - igniter and valve are on in activation, only the valve in recognition.
module furnace_timing_config #(
    parameter int unsigned SEC_CYCLES = furnace_timing_pkg::SEC_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  field_timing_switches,
    input  wire logic [1:0]  safety_timing_switches,
    input  wire logic        lock_jumper_fitted,
    input  wire logic        heat_cycle_done,
    input  wire logic        cool_off_start,
    input  wire logic        heat_off_start,
    input  wire logic        trial_start,
    input  wire logic        first_trial,
    input  wire logic        nvm_valid,
    input  wire logic [1:0]  nvm_rdata,
    output logic             nvm_write,
    output logic [1:0]       nvm_wdata,
    output logic             safety_locked,
    output logic [1:0]       safety_sel,
    output logic [11:0]      prepurge_s,
    output logic [11:0]      interpurge_s,
    output logic [11:0]      postpurge_s,
    output logic [11:0]      cool_on_delay_s,
    output logic [11:0]      cool_off_delay_s,
    output logic [1:0]       max_retries,
    output logic [1:0]       max_recycles,
    output logic [11:0]      restart_delay_s,
    output logic [11:0]      flame_fail_s,
    output logic [11:0]      comp_off_s,
    output logic [11:0]      false_flame_s,
    output logic [11:0]      heat_on_delay_s,
    output logic [11:0]      heat_off_delay_s,
    output logic [11:0]      warmup_s,
    output logic             igniter_on,
    output logic             valve_on,
    output logic             trial_done
);
    typedef struct packed {
        logic [3:0]  fs1;
        logic [3:0]  fs2;
        logic [1:0]  ss1;
        logic [1:0]  ss2;
        logic        js1;
        logic        js2;
        logic        init;
        logic        locked;
        logic [1:0]  stored;
        logic [1:0]  prev;
        logic [3:0]  cycles;
        logic        wr;
        logic        cool_off_sel;
        logic        heat_on_sel;
        logic [1:0]  heat_off_sel;
        logic [24:0] tick;
        furnace_timing_pkg::trial_state_t trial;
        logic [3:0]  secs;
        logic [3:0]  act_len;
        logic        done;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [1:0] sel;
    logic       sec_pulse;

    localparam logic [24:0] TICK_LAST = 25'(SEC_CYCLES - 1);

    // safety selection in force: the stored copy wins once locked
    assign sel       = st_r.locked ? st_r.stored : st_r.ss2; // R3
    assign sec_pulse = (st_r.tick == TICK_LAST);

    always_comb begin
        st_nxt     = st_r;
        st_nxt.fs1 = field_timing_switches;
        st_nxt.fs2 = st_r.fs1;
        st_nxt.ss1 = safety_timing_switches;
        st_nxt.ss2 = st_r.ss1;
        st_nxt.js1 = lock_jumper_fitted;
        st_nxt.js2 = st_r.js1;
        st_nxt.wr  = 1'b0;
        st_nxt.done = 1'b0;
        st_nxt.init = 1'b0;
        // store contents caught on the first clock after reset release
        if (st_r.init) begin
            if (nvm_valid) begin
                st_nxt.locked = 1'b1;
                st_nxt.stored = nvm_rdata;
            end
            st_nxt.prev = st_r.ss2;
        end else if (!st_r.locked) begin
            if (st_r.ss2 != st_r.prev) begin
                st_nxt.prev   = st_r.ss2;
                st_nxt.cycles = 4'h0; // R1
            end else if (!st_r.js2) begin
                st_nxt.locked = 1'b1; // R2
                st_nxt.stored = st_r.ss2;
                st_nxt.wr     = 1'b1;
            end else if (heat_cycle_done) begin
                if (st_r.cycles == furnace_timing_pkg::LOCK_CYCLES - 4'h1) begin
                    st_nxt.locked = 1'b1; // R1
                    st_nxt.stored = st_r.ss2;
                    st_nxt.wr     = 1'b1;
                end else begin
                    st_nxt.cycles = st_r.cycles + 4'h1;
                end
            end
        end
        // field values latched only when a delay starts
        if (cool_off_start) begin
            st_nxt.cool_off_sel = st_r.fs2[3]; // R4
        end
        if (heat_off_start) begin
            st_nxt.heat_off_sel = st_r.fs2[1:0]; // R4
        end
        if (trial_start) begin
            st_nxt.heat_on_sel = st_r.fs2[2]; // R12
        end
        // one-second base restarts with each trial so phases are exact
        if (trial_start || sec_pulse) begin
            st_nxt.tick = 25'h0;
        end else begin
            st_nxt.tick = st_r.tick + 25'h1;
        end
        case (st_r.trial)
            furnace_timing_pkg::TRIAL_IDLE: begin
                if (trial_start) begin
                    st_nxt.trial = furnace_timing_pkg::TRIAL_ACT;
                    st_nxt.secs  = 4'h0;
                    case (sel) // R15
                        2'b00:   st_nxt.act_len = furnace_timing_pkg::ACT_00_S;
                        2'b11:   st_nxt.act_len = furnace_timing_pkg::ACT_11_S;
                        default: st_nxt.act_len = furnace_timing_pkg::ACT_MID_S;
                    endcase
                end
            end
            furnace_timing_pkg::TRIAL_ACT: begin
                if (sec_pulse) begin
                    if (st_r.secs == st_r.act_len - 4'h1) begin
                        st_nxt.trial = furnace_timing_pkg::TRIAL_RECOG; // R17
                        st_nxt.secs  = 4'h0;
                    end else begin
                        st_nxt.secs = st_r.secs + 4'h1;
                    end
                end
            end
            furnace_timing_pkg::TRIAL_RECOG: begin
                if (sec_pulse) begin
                    if (st_r.secs == furnace_timing_pkg::RECOG_S - 4'h1) begin
                        st_nxt.trial = furnace_timing_pkg::TRIAL_IDLE; // R15
                        st_nxt.done  = 1'b1;
                    end else begin
                        st_nxt.secs = st_r.secs + 4'h1;
                    end
                end
            end
            default: begin
                st_nxt.trial = furnace_timing_pkg::TRIAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r              <= '0;
            st_r.fs1          <= furnace_timing_pkg::FIELD_RESET; // R16
            st_r.fs2          <= furnace_timing_pkg::FIELD_RESET;
            st_r.ss1          <= furnace_timing_pkg::SAFETY_RESET;
            st_r.ss2          <= furnace_timing_pkg::SAFETY_RESET;
            st_r.prev         <= furnace_timing_pkg::SAFETY_RESET;
            st_r.js1          <= 1'b1;
            st_r.js2          <= 1'b1;
            st_r.init         <= 1'b1;
            st_r.trial        <= furnace_timing_pkg::TRIAL_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign nvm_write     = st_r.wr;
    assign nvm_wdata     = st_r.stored;
    assign safety_locked = st_r.locked;
    assign safety_sel    = sel;
    assign prepurge_s      = furnace_timing_pkg::PREPURGE_S; // R5
    assign interpurge_s    = furnace_timing_pkg::INTERPURGE_S; // R5
    assign postpurge_s     = furnace_timing_pkg::POSTPURGE_S; // R5
    assign cool_on_delay_s = furnace_timing_pkg::COOL_ON_S; // R6
    assign cool_off_delay_s = st_r.cool_off_sel ? furnace_timing_pkg::COOL_OFF_HI_S
                                                : furnace_timing_pkg::COOL_OFF_LO_S; // R6
    assign max_retries     = furnace_timing_pkg::MAX_RETRIES; // R7
    assign max_recycles    = furnace_timing_pkg::MAX_RECYCLES; // R8
    assign restart_delay_s = furnace_timing_pkg::RESTART_S; // R7
    assign flame_fail_s    = furnace_timing_pkg::FLAME_FAIL_S; // R9
    assign comp_off_s      = furnace_timing_pkg::COMP_OFF_S; // R10
    assign false_flame_s   = furnace_timing_pkg::FALSE_FLAME_S; // R11
    assign heat_on_delay_s = st_r.heat_on_sel ? furnace_timing_pkg::HEAT_ON_HI_S
                                              : furnace_timing_pkg::HEAT_ON_LO_S; // R12

    always_comb begin
        case (st_r.heat_off_sel) // R13
            2'b00:   heat_off_delay_s = furnace_timing_pkg::HEAT_OFF_00_S;
            2'b01:   heat_off_delay_s = furnace_timing_pkg::HEAT_OFF_01_S;
            2'b10:   heat_off_delay_s = furnace_timing_pkg::HEAT_OFF_10_S;
            default: heat_off_delay_s = furnace_timing_pkg::HEAT_OFF_11_S;
        endcase
    end

    // sel[1] is select_bit_one, sel[0] is select_bit_two
    assign warmup_s = sel[1] ? furnace_timing_pkg::WARM_LONG_S :
                      (first_trial ? furnace_timing_pkg::WARM_FIRST_S
                                   : furnace_timing_pkg::WARM_NEXT_S); // R14
    assign igniter_on = (st_r.trial == furnace_timing_pkg::TRIAL_ACT); // R17
    assign valve_on   = (st_r.trial != furnace_timing_pkg::TRIAL_IDLE); // R17
    assign trial_done = st_r.done;

    chk_jumper_commits: assert property (@(posedge clk) disable iff (sys_rst) // R2
        (!st_r.init && !st_r.locked && !st_r.js2 && st_r.ss2 == st_r.prev)
        |=> (safety_locked && nvm_write && nvm_wdata == $past(st_r.ss2)))
        else $error("jumper removal did not commit selection");
    chk_locked_holds: assert property (@(posedge clk) disable iff (sys_rst) // R3
        safety_locked |=> (safety_locked && $stable(safety_sel)))
        else $error("stored safety selection changed");
    chk_tenth_cycle: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (nvm_write && $past(st_r.js2))
        |-> ($past(st_r.cycles) == 4'h9 && $past(heat_cycle_done)))
        else $error("cycle commit not on tenth heat cycle");
    chk_single_write: assert property (@(posedge clk) disable iff (sys_rst) // R1
        nvm_write |=> !nvm_write [*8])
        else $error("store written more than once");
    chk_latch_stable: assert property (@(posedge clk) disable iff (sys_rst) // R4
        !heat_off_start |=> $stable(heat_off_delay_s))
        else $error("heat off delay changed while running");
    chk_heat_on_latch: assert property (@(posedge clk) disable iff (sys_rst) // R12
        trial_start |=> (heat_on_delay_s == ($past(st_r.fs2[2]) ?
            furnace_timing_pkg::HEAT_ON_HI_S : furnace_timing_pkg::HEAT_ON_LO_S)))
        else $error("heat on delay not taken at trial entry");
    chk_igniter_valve: assert property (@(posedge clk) disable iff (sys_rst) // R17
        igniter_on |-> valve_on)
        else $error("igniter on without valve");
    chk_trial_enter: assert property (@(posedge clk) disable iff (sys_rst) // R15
        (trial_start && !valve_on) |=> (igniter_on && st_r.act_len ==
            ($past(sel) == 2'b00 ? 4'h1 : ($past(sel) == 2'b11 ? 4'h5 : 4'h3))))
        else $error("trial did not start with correct activation");
    chk_warmup_long: assert property (@(posedge clk) disable iff (sys_rst) // R14
        sel[1] |-> (warmup_s == 12'h01e))
        else $error("warm-up not 30 s");
    chk_warmup_short: assert property (@(posedge clk) disable iff (sys_rst) // R14
        !sel[1] |-> (warmup_s == (first_trial ? 12'h011 : 12'h01b)))
        else $error("warm-up not 17 s first and 27 s later");
    chk_cool_off_take: assert property (@(posedge clk) disable iff (sys_rst) // R6
        cool_off_start |=> (cool_off_delay_s == ($past(st_r.fs2[3]) ? 12'h03c : 12'h000)))
        else $error("cool off delay not taken at its start");
    chk_cool_off_held: assert property (@(posedge clk) disable iff (sys_rst) // R4
        !cool_off_start |=> $stable(cool_off_delay_s))
        else $error("cool off delay changed while running");
    chk_heat_on_held: assert property (@(posedge clk) disable iff (sys_rst) // R4
        !trial_start |=> $stable(heat_on_delay_s))
        else $error("heat on delay changed while running");
    chk_heat_off_take: assert property (@(posedge clk) disable iff (sys_rst) // R13
        heat_off_start |=> (heat_off_delay_s ==
            ($past(st_r.fs2[1:0]) == 2'b00 ? 12'h078 :
            ($past(st_r.fs2[1:0]) == 2'b01 ? 12'h0b4 :
            ($past(st_r.fs2[1:0]) == 2'b10 ? 12'h05a : 12'h03c)))))
        else $error("heat off delay not taken from the select");
    chk_ign_then_valve: assert property (@(posedge clk) disable iff (sys_rst) // R17
        $fell(igniter_on) |-> (valve_on && !trial_done))
        else $error("valve closed when igniter went off");
    chk_done_ends_valve: assert property (@(posedge clk) disable iff (sys_rst) // R15
        trial_done |-> (!valve_on && $past(valve_on)))
        else $error("trial end not at valve close");
    chk_cycle_restart: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (!st_r.init && !st_r.locked && st_r.ss2 != st_r.prev)
        |=> (!nvm_write && st_r.cycles == 4'h0))
        else $error("switch change did not restart the cycle count");
    chk_locked_no_write: assert property (@(posedge clk) disable iff (sys_rst) // R3
        safety_locked |=> !nvm_write)
        else $error("store written after lock");
    chk_write_value: assert property (@(posedge clk) disable iff (sys_rst) // R1
        nvm_write |-> (safety_locked && nvm_wdata == $past(st_r.ss2)))
        else $error("stored value is not the selection in force");
    chk_restore_lock: assert property (@(posedge clk) disable iff (sys_rst) // R3
        (st_r.init && nvm_valid) |=> (safety_locked && safety_sel == $past(nvm_rdata)))
        else $error("stored selection not restored");
endmodule
`default_nettype wire

// ### nvm_store_model.sv
// non-volatile store model that sits beside the timing setup block
// assumes nvm_write is a one-cycle pulse on clk; contents outlive sys_rst
`timescale 1ns/1ns
`default_nettype none
module nvm_store_model (
    input  wire logic       clk,
    input  wire logic       wipe,
    input  wire logic       nvm_write,
    input  wire logic [1:0] nvm_wdata,
    output logic            nvm_valid,
    output logic [1:0]      nvm_rdata
);
    logic [1:0] cell_r = 2'h0;
    logic       full_r = 1'b0;
    // no reset pin: a controller reset must not erase the store
    always @(posedge clk) begin
        if (wipe) begin
            full_r <= 1'b0;
        end else if (nvm_write === 1'b1) begin
            cell_r <= nvm_wdata;
            full_r <= 1'b1;
        end
    end
    assign nvm_valid = full_r;
    // an empty store shows the inverse, so a stale value cannot pass
    assign nvm_rdata = full_r ? cell_r : ~cell_r;
endmodule
`default_nettype wire

// ### furnace_timing_config_bench.sv
// self-checking bench for the furnace timing setup block
// assumes SEC_CYCLES is shortened to 4; inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module furnace_timing_config_bench;
    localparam int unsigned S = 4;
    localparam logic [39:0] ROWS [4] = '{{4'h0, 12'h000, 12'h01e, 12'h078},
        {4'h1, 12'h000, 12'h01e, 12'h0b4}, {4'ha, 12'h03c, 12'h01e, 12'h05a},
        {4'h7, 12'h000, 12'h03c, 12'h03c}};
    logic        clk, sys_rst, jmp, ft, wipe, nv, nw, lk, ign, vlv, td;
    logic [3:0]  fsw, stb;
    logic [1:0]  ssw, nr, nwd, sel, mrt, mrc;
    logic [11:0] pre, itp, pst, con, cof, rsd, ffs, cmp, fls, hon, hof, wrm;
    int          num_errors = 0;
    int          n_checks = 0;
    int          n_wr = 0;

    furnace_timing_config #(.SEC_CYCLES(S)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .field_timing_switches(fsw), .safety_timing_switches(ssw),
        .lock_jumper_fitted(jmp), .heat_cycle_done(stb[3]), .cool_off_start(stb[2]),
        .heat_off_start(stb[1]), .trial_start(stb[0]), .first_trial(ft),
        .nvm_valid(nv), .nvm_rdata(nr), .nvm_write(nw), .nvm_wdata(nwd),
        .safety_locked(lk), .safety_sel(sel), .prepurge_s(pre), .interpurge_s(itp),
        .postpurge_s(pst), .cool_on_delay_s(con), .cool_off_delay_s(cof),
        .max_retries(mrt), .max_recycles(mrc), .restart_delay_s(rsd),
        .flame_fail_s(ffs), .comp_off_s(cmp), .false_flame_s(fls),
        .heat_on_delay_s(hon), .heat_off_delay_s(hof), .warmup_s(wrm),
        .igniter_on(ign), .valve_on(vlv), .trial_done(td));
    nvm_store_model u_store (.clk(clk), .wipe(wipe), .nvm_write(nw), .nvm_wdata(nwd),
        .nvm_valid(nv), .nvm_rdata(nr));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nw === 1'b1) n_wr++;
    end

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // strobe held n cycles, then one idle cycle before the next call
    task pulse(input logic [3:0] m, input int n);
        stb = m;
        tick(n);
        stb = 4'h0;
        tick(1);
    endtask
    task reboot;
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(3);
    endtask
    task automatic trial(input int act);
        int ni;
        int nv2;
        int k;
        ni = 0;
        nv2 = 0;
        stb = 4'h1;
        tick(1);
        stb = 4'h0;
        for (k = 0; k < 200 && td !== 1'b1; k++) begin
            ni += (ign === 1'b1);
            nv2 += (vlv === 1'b1);
            tick(1);
        end
        if (k == 200) begin
            num_errors++;
            $display("ERROR trial_done expected 1 seen 0");
            end_of_test();
        end
        chk("igniter cycles", act * S, ni);
        chk("valve cycles", (act + 3) * S, nv2);
        tick(1);
        chk("done pulse", 1'b0, td);
    endtask

    initial begin
        sys_rst = 1'b1;
        fsw = 4'h0;
        ssw = 2'h0;
        jmp = 1'b1;
        stb = 4'h0;
        ft = 1'b1;
        wipe = 1'b0;
        tick(6);
        sys_rst = 1'b0;
        tick(3);
        chk("defaults", {12'h000, 12'h01e, 12'h078, 5'h00},
            {cof, hon, hof, lk, sel, ign, vlv});
        chk("purges", {12'h01e, 12'h03c, 12'h00f, 12'h005}, {pre, itp, pst, con});
        chk("limits", {2'h2, 2'h3, 12'he10, 12'h002, 12'h12c, 12'h014},
            {mrt, mrc, rsd, ffs, cmp, fls});
        $display("reset and fixed values done");
        for (int r = 0; r < 4; r++) begin
            fsw = ROWS[r][39:36];
            tick(3);
            pulse(4'h6, 1);
            trial(1);
            chk("field delays", ROWS[r][35:0], {cof, hon, hof});
            fsw = ~ROWS[r][39:36];
            tick(3);
            chk("field held", ROWS[r][35:0], {cof, hon, hof});
        end
        $display("field rows done");
        for (int s = 0; s < 4; s++) begin
            ssw = s[1:0];
            ft = 1'b1;
            tick(3);
            chk("warm first", s[1] ? 12'h01e : 12'h011, wrm);
            ft = 1'b0;
            tick(1);
            chk("warm next", {s[1] ? 12'h01e : 12'h01b, s[1:0]}, {wrm, sel});
            trial(s == 0 ? 1 : s == 3 ? 5 : 3);
        end
        $display("safety rows done");
        // a switch change in mid-count restarts the ten cycles
        ssw = 2'h1;
        tick(3);
        pulse(4'h8, 9);
        ssw = 2'h2;
        tick(3);
        pulse(4'h8, 9);
        chk("no early write", 0, n_wr);
        pulse(4'h8, 1);
        tick(2);
        chk("cycle lock", {32'h1, 2'h2, 1'b1}, {n_wr, nwd, lk});
        ssw = 2'h1;
        tick(3);
        pulse(4'h8, 10);
        chk("locked sel", {2'h2, 32'h1}, {sel, n_wr});
        reboot();
        chk("restored", {2'h2, 1'b1}, {sel, lk});
        $display("cycle lock done");
        wipe = 1'b1;
        tick(1);
        wipe = 1'b0;
        ssw = 2'h3;
        reboot();
        chk("unlocked", {2'h3, 1'b0}, {sel, lk});
        jmp = 1'b0;
        tick(5);
        chk("jumper lock", {32'h2, 2'h3, 1'b1}, {n_wr, nwd, lk});
        ssw = 2'h0;
        tick(3);
        chk("jumper held", 2'h3, sel);
        $display("jumper lock done");
        end_of_test();
    end
endmodule
`default_nettype wire
